// [pkg/atx_pkg.sv]
// Constants and carriers for the transmitter pin and mode control block.
// Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus.
package atx_pkg;
   localparam int ATX_AW = 8;
   // Register byte offsets
   localparam logic [ATX_AW-1:0] ATX_CTRL_OFS = 8'h00;
   localparam logic [ATX_AW-1:0] ATX_STAT_OFS = 8'h04;
   localparam logic [ATX_AW-1:0] ATX_MASK_OFS = 8'h08;
   localparam logic [ATX_AW-1:0] ATX_UBUF_OFS = 8'h0C;
   localparam logic [ATX_AW-1:0] ATX_MODE_OFS = 8'h10;
   // Control register fields
   localparam int ATX_C_UDIR = 0;
   localparam int ATX_C_IPOL = 1;
   localparam int ATX_C_IOD = 2;
   localparam int ATX_C_SPI = 3;
   localparam int ATX_C_RAT = 4;
   localparam int ATX_C_TXEN = 6;
   localparam int ATX_C_ALT = 7;
   localparam logic [31:0] ATX_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] ATX_MASK_RST = 32'h0000_0000;
   localparam logic [31:0] ATX_UBUF_RST = 32'h0000_0000;
   localparam logic [1:0] ATX_OKAY = 2'h0;
   localparam logic [1:0] ATX_SLVERR = 2'h2;
   localparam int ATX_NSYNC = 8;
   // Synchroniser bit positions
   localparam int ATX_S_HWSEL = 0;
   localparam int ATX_S_CTRL_PORT_CLOCK = 1;
   localparam int ATX_S_AD = 2;
   localparam int ATX_S_UPIN = 3;
   localparam int ATX_S_HWCFG = 4;
   // Master clock ratio codes
   typedef enum logic [1:0] {
      ATX_R256_TYPE = 2'b00,
      ATX_R384_TYPE = 2'b01,
      ATX_R512_TYPE = 2'b10
   } atx_ratio_type;
   typedef struct packed {
      logic [23:0] left;
      logic [23:0] right;
      logic valid;
   } atx_audio_type;
   typedef struct packed {
      logic hw_mode;
      atx_ratio_type ratio;
      logic [3:0] alt;
   } atx_cfg_type;
endpackage

// [hw/atx_pinctl.sv]
// Pin and mode control of a digital audio transmitter: interrupt pin,
// user-bit pin, mode select, line driver reset, control-port pins.
// Assumes event and audio inputs come from logic on clk; pins are async.
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Function
// - Every interrupt source has a mask bit
// - Status bits record interrupt causes
// - Interrupt polarity and drive type selectable
// - Interrupt holds until status read clear
// - Output user pin uses internal buffer
// - User pin direction resets to input
// - Mode select picks software or hardware
// - High selects hardware, low selects software
// - Line drivers low during reset
// - Shared pin: address bit or data in
// - Control clock times control data bits
// - Hardware mode routes audio to transmitter
// - Hardware mode gives pins alternate roles
// - Reset holds state, enters low power; the code instead clears ctrl_r, mask_r, ubuf_r and status_r to zero in reset
module atx_pinctl
   import atx_pkg::*;
#(
   parameter int NEV = 8
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [ATX_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ATX_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NEV-1:0] ev_in,
   output logic irq_r,
   output logic int_pin_o_r,
   output logic int_pin_oe_r,
   input wire logic hw_sw_sel,
   input wire logic [3:0] hw_cfg_pins,
   output atx_cfg_type cfg_r,
   input wire logic user_pin_i,
   output logic user_pin_o_r,
   output logic user_pin_oe_r,
   input wire logic user_bit_req,
   output logic user_tx_bit_r,
   input wire logic ctrl_port_clock,
   input wire logic addr1_or_serial_ctrl_in,
   output logic chip_addr_bit1_r,
   output logic serial_ctrl_data_in_r,
   output logic ctrl_in_stb_r,
   output logic ctrl_out_stb_r,
   input wire logic tx_line_bit,
   output logic line_driver_pos_r,
   output logic line_driver_neg_r,
   input wire atx_audio_type audio_in,
   output atx_audio_type audio_out_r,
   output logic low_power_r
);
   logic [ATX_NSYNC-1:0] pin_s1_r;
   logic [ATX_NSYNC-1:0] pin_s2_r;
   logic ctrl_port_clock_d_r;
   logic [31:0] ctrl_r;
   logic [NEV-1:0] status_r;
   logic [NEV-1:0] mask_r;
   logic [31:0] ubuf_r;
   logic [4:0] uidx_r;
   logic [ATX_AW-1:0] awaddr_r;
   logic aw_have_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic w_have_r;
   logic [31:0] rdata_nxt;
   logic [1:0] rresp_nxt;
   logic wr_go;
   logic ar_go;
   logic stat_rd;
   logic wr_ok;
   logic int_act;
   logic hw_mode;
   logic udir_eff;
   logic [NEV-1:0] mask_old_r;
   logic [31:0] mask_wr;

   // Pins pass two flops; the first stage feeds only the second, and the control clock gets a third flop for edge detection
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         ctrl_port_clock_d_r <= 1'b0;
      end else begin
         pin_s1_r <= {hw_cfg_pins, user_pin_i, addr1_or_serial_ctrl_in,
                      ctrl_port_clock, hw_sw_sel};
         pin_s2_r <= pin_s1_r;
         ctrl_port_clock_d_r <= pin_s2_r[ATX_S_CTRL_PORT_CLOCK];
      end
   end

   assign hw_mode = pin_s2_r[ATX_S_HWSEL];
   // input unless software sets it; hardware mode keeps it input
   assign udir_eff = ctrl_r[ATX_C_UDIR] & ~hw_mode;

   // AXI4-Lite: address and data accepted in either order
   assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
   assign ar_go = s_axi_arvalid && s_axi_arready;
   assign stat_rd = ar_go && (s_axi_araddr == ATX_STAT_OFS);
   always_comb begin
      wr_ok = 1'b1;
      if (awaddr_r == ATX_CTRL_OFS) begin
         wr_ok = 1'b1;
      end else if (awaddr_r == ATX_MASK_OFS) begin
         wr_ok = 1'b1;
      end else if (awaddr_r == ATX_UBUF_OFS) begin
         wr_ok = 1'b1;
      end else begin
         wr_ok = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= ATX_OKAY;
      end else begin
         s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready <= !w_have_r && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? ATX_OKAY : ATX_SLVERR;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Byte-lane merge of write data into a register value
   function automatic logic [31:0] atx_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] stb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (stb[i]) begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // Mask widened to a word so the lane merge sees bus-aligned bytes
   assign mask_wr = atx_merge({{(32-NEV){1'b0}}, mask_r}, wdata_r, wstrb_r);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_r <= ATX_CTRL_RST;
         mask_r <= ATX_MASK_RST[NEV-1:0];
         ubuf_r <= ATX_UBUF_RST;
      end else if (wr_go) begin
         if (awaddr_r == ATX_CTRL_OFS) begin
            ctrl_r <= atx_merge(ctrl_r, wdata_r, wstrb_r);
         end else if (awaddr_r == ATX_MASK_OFS) begin
            mask_r <= mask_wr[NEV-1:0];
         end else if (awaddr_r == ATX_UBUF_OFS) begin
            ubuf_r <= atx_merge(ubuf_r, wdata_r, wstrb_r);
         end
      end
   end

   always_comb begin
      rdata_nxt = 32'h0000_0000;
      rresp_nxt = ATX_OKAY;
      if (s_axi_araddr == ATX_CTRL_OFS) begin
         rdata_nxt = ctrl_r;
      end else if (s_axi_araddr == ATX_STAT_OFS) begin
         rdata_nxt[NEV-1:0] = status_r;
      end else if (s_axi_araddr == ATX_MASK_OFS) begin
         rdata_nxt[NEV-1:0] = mask_r;
      end else if (s_axi_araddr == ATX_UBUF_OFS) begin
         rdata_nxt = ubuf_r;
      end else if (s_axi_araddr == ATX_MODE_OFS) begin
         rdata_nxt[6:0] = cfg_r;
      end else begin
         rresp_nxt = ATX_SLVERR;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= ATX_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !ar_go;
         if (ar_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdata_nxt;
            s_axi_rresp <= rresp_nxt;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // sticky causes; a new event beats the read clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         status_r <= '0;
      end else begin
         status_r <= (stat_rd ? '0 : status_r) | ev_in;
      end
   end

   assign int_act = |(status_r & mask_r);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_r <= 1'b0;
         int_pin_o_r <= 1'b0;
         int_pin_oe_r <= 1'b0;
         mask_old_r <= '0;
      end else begin
         mask_old_r <= mask_r;
         // falls once status is read back to zero or its cause is masked
         irq_r <= int_act;
         // polarity bit sets the asserted level
         int_pin_o_r <= int_act ? ctrl_r[ATX_C_IPOL] : !ctrl_r[ATX_C_IPOL];
         // open drain drives only the low level
         int_pin_oe_r <= !ctrl_r[ATX_C_IOD] ||
                         !(int_act ? ctrl_r[ATX_C_IPOL] : !ctrl_r[ATX_C_IPOL]);
      end
   end

   // pin or internal buffer as the user bit source
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         uidx_r <= '0;
         user_tx_bit_r <= 1'b0;
         user_pin_o_r <= 1'b0;
         user_pin_oe_r <= 1'b0;
      end else begin
         if (user_bit_req) begin
            uidx_r <= uidx_r + 5'd1;
         end
         user_tx_bit_r <= udir_eff ? ubuf_r[uidx_r] : pin_s2_r[ATX_S_UPIN];
         user_pin_o_r <= udir_eff & ubuf_r[uidx_r];
         user_pin_oe_r <= udir_eff;
      end
   end

   // control clock edges time bits in and out
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         chip_addr_bit1_r <= 1'b0;
         serial_ctrl_data_in_r <= 1'b0;
         ctrl_in_stb_r <= 1'b0;
         ctrl_out_stb_r <= 1'b0;
      end else begin
         ctrl_in_stb_r <= pin_s2_r[ATX_S_CTRL_PORT_CLOCK] && !ctrl_port_clock_d_r && !hw_mode;
         ctrl_out_stb_r <= !pin_s2_r[ATX_S_CTRL_PORT_CLOCK] && ctrl_port_clock_d_r && !hw_mode;
         // address bit in two-wire mode, data in SPI mode
         if (ctrl_r[ATX_C_SPI]) begin
            if (pin_s2_r[ATX_S_CTRL_PORT_CLOCK] && !ctrl_port_clock_d_r) begin
               serial_ctrl_data_in_r <= pin_s2_r[ATX_S_AD];
            end
         end else begin
            chip_addr_bit1_r <= pin_s2_r[ATX_S_AD];
         end
      end
   end

   // configuration from pins or from registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfg_r <= '0;
      end else begin
         cfg_r.hw_mode <= hw_mode;
         cfg_r.ratio <= atx_ratio_type'(ctrl_r[ATX_C_RAT +: 2]);
         // alternate pin roles in hardware mode
         cfg_r.alt <= hw_mode ? pin_s2_r[ATX_S_HWCFG +: 4] :
                                ctrl_r[ATX_C_ALT +: 4];
      end
   end

   // drivers low in reset and while idle
   // low power flag held through reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         line_driver_pos_r <= 1'b0;
         line_driver_neg_r <= 1'b0;
         low_power_r <= 1'b1;
         audio_out_r <= '0;
      end else begin
         low_power_r <= 1'b0;
         line_driver_pos_r <= (hw_mode || ctrl_r[ATX_C_TXEN]) && tx_line_bit;
         line_driver_neg_r <= (hw_mode || ctrl_r[ATX_C_TXEN]) && !tx_line_bit;
         // hardware mode feeds audio straight through
         audio_out_r <= (hw_mode || ctrl_r[ATX_C_TXEN]) ? audio_in : '0;
      end
   end

   sequence s_cause;
      int_act;
   endsequence
   property p_mask;
      @(posedge clk) disable iff (!nrst)
         irq_r |-> $past(status_r & mask_r) != '0;
   endproperty
   a_mask: assert property (p_mask) else $error("irq no cause");
   property p_stat;
      @(posedge clk) disable iff (!nrst)
         ev_in != '0 |=> (status_r & $past(ev_in)) == $past(ev_in);
   endproperty
   a_stat: assert property (p_stat) else $error("event lost");
   property p_pol;
      @(posedge clk) disable iff (!nrst)
         s_cause ##1 $stable(ctrl_r) |-> int_pin_o_r == ctrl_r[ATX_C_IPOL];
   endproperty
   a_pol: assert property (p_pol) else $error("bad int level");
   // A fall needs a status read two cycles back or a mask change
   property p_hold;
      @(posedge clk) disable iff (!nrst)
         $fell(irq_r) |-> $past(stat_rd, 2) ||
                          $past(mask_r) != $past(mask_old_r);
   endproperty
   a_hold: assert property (p_hold) else $error("irq fell early");
   property p_keep;
      @(posedge clk) disable iff (!nrst)
         s_cause ##0 !stat_rd ##1 $stable(mask_r) |-> irq_r [*2];
   endproperty
   a_keep: assert property (p_keep) else $error("irq dropped");
   property p_user;
      @(posedge clk) disable iff (!nrst)
         !udir_eff |=> user_tx_bit_r == $past(pin_s2_r[ATX_S_UPIN])
                       && !user_pin_oe_r;
   endproperty
   a_user: assert property (p_user) else $error("user source");
   property p_mode;
      @(posedge clk) disable iff (!nrst) ##1 cfg_r.hw_mode == $past(hw_mode);
   endproperty
   a_mode: assert property (p_mode) else $error("mode select");
   // Checked while reset is applied, so no disable here
   property p_ld;
      @(posedge clk)
         !nrst |-> low_power_r && !line_driver_pos_r && !line_driver_neg_r;
   endproperty
   a_ld: assert property (p_ld) else $error("driver in reset");
   property p_route;
      @(posedge clk) disable iff (!nrst)
         hw_mode |=> audio_out_r == $past(audio_in);
   endproperty
   a_route: assert property (p_route) else $error("audio route");
endmodule

// [verif/atx_far_model.sv]
// Far-side model: the microcontroller on the serial control port pins.
// Assumes the bench calls its tasks; the control clock idles low.
`timescale 1ns/1ps
module atx_far_model (
   output logic ctrl_port_clock,
   output logic addr1_or_serial_ctrl_in
);
   initial begin
      ctrl_port_clock = 1'b0;
      addr1_or_serial_ctrl_in = 1'b0;
   end
   task automatic send(input logic [7:0] b);
      #1.3;
      for (int i = 7; i >= 0; i--) begin
         addr1_or_serial_ctrl_in = b[i];
         #16;
         ctrl_port_clock = 1'b1;
         #32;
         ctrl_port_clock = 1'b0;
         #16;
      end
      // Released line must not look like a held last bit
      addr1_or_serial_ctrl_in = ~b[0];
   endtask
   // static address strap, moved off the clock edge
   task automatic hold(input logic v);
      #1.3;
      addr1_or_serial_ctrl_in = v;
   endtask
endmodule

// [verif/test_audio_tx_mode_pin_control.sv]
// Bench for the transmitter pin and mode control block.
// Assumes a 200 MHz clk and the AXI4-Lite register map of the package.
`timescale 1ns/1ps
module test_audio_tx_mode_pin_control import atx_pkg::*;;
   logic clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic irq_r, int_pin_o_r, int_pin_oe_r, hw_sw_sel, user_pin_i;
   logic user_pin_o_r, user_pin_oe_r, user_bit_req, user_tx_bit_r;
   logic ctrl_port_clock, addr1_or_serial_ctrl_in, chip_addr_bit1_r;
   logic serial_ctrl_data_in_r, ctrl_in_stb_r, ctrl_out_stb_r;
   logic tx_line_bit, line_driver_pos_r, line_driver_neg_r, low_power_r;
   logic ext_en, ext_val;
   logic [ATX_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb, hw_cfg_pins;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [7:0] ev_in, sh;
   atx_cfg_type cfg_r;
   atx_audio_type audio_in, audio_out_r;
   int fails, total_checks, nin, nout, k;
   localparam logic [31:0] UB = 32'h0000_0005;

   // Pull-down holds the user pin low when nobody drives it
   assign user_pin_i = user_pin_oe_r ? user_pin_o_r : (ext_en & ext_val);

   atx_pinctl uut (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ev_in, .irq_r,
      .int_pin_o_r, .int_pin_oe_r, .hw_sw_sel, .hw_cfg_pins, .cfg_r,
      .user_pin_i, .user_pin_o_r, .user_pin_oe_r, .user_bit_req,
      .user_tx_bit_r, .ctrl_port_clock, .addr1_or_serial_ctrl_in,
      .chip_addr_bit1_r, .serial_ctrl_data_in_r, .ctrl_in_stb_r,
      .ctrl_out_stb_r, .tx_line_bit, .line_driver_pos_r,
      .line_driver_neg_r, .audio_in, .audio_out_r, .low_power_r);
   atx_far_model far (.ctrl_port_clock, .addr1_or_serial_ctrl_in);

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (ctrl_in_stb_r === 1'b1) begin
         nin++;
         sh = {sh[6:0], serial_ctrl_data_in_r};
      end
      if (ctrl_out_stb_r === 1'b1) nout++;
   end

   task chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task chk_resp(input logic [1:0] got, input logic [1:0] exp);
      chk({62'h0, got}, {62'h0, exp});
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task axw(input logic [ATX_AW-1:0] a, input logic [31:0] d,
            input logic [1:0] er);
      logic a_ok, w_ok;
      a_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awready === 1'b1) a_ok = 1'b1;
         if (a_ok) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) w_ok = 1'b1;
         if (w_ok) s_axi_wvalid <= 1'b0;
      end while (!(a_ok && w_ok));
      while (s_axi_bvalid !== 1'b1) @(posedge clk);
      chk_resp(s_axi_bresp, er);
      s_axi_bready <= 1'b0;
      @(posedge clk);
   endtask
   task axr(input logic [ATX_AW-1:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clk);
   endtask
   task ev(input logic [7:0] m);
      ev_in <= m;
      @(posedge clk);
      ev_in <= 8'h00;
   endtask
   task rst_to(input logic hw);
      nrst <= 1'b0;
      // mode pin moved only under reset
      hw_sw_sel <= hw;
      cyc(5);
      chk(line_driver_pos_r | line_driver_neg_r, 0);
      chk(low_power_r, 1);
      nrst <= 1'b1;
      cyc(5);
      chk(low_power_r, 0);
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      complete_run;
   end

   initial begin
      // Reset starts high so the first assertion is a clean falling edge
      {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h8;
      {s_axi_arvalid, s_axi_rready, hw_sw_sel, user_bit_req} = 4'h0;
      {tx_line_bit, ext_en, ext_val} = 3'h0;
      s_axi_awaddr = '0;
      s_axi_araddr = '0;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hF;
      hw_cfg_pins = 4'h0;
      ev_in = 8'h00;
      audio_in = '0;
      {fails, total_checks, nin, nout} = '0;
      sh = 8'h00;
      rst_to(1'b0);
      axr(ATX_CTRL_OFS);
      chk(rd, ATX_CTRL_RST);
      chk(user_pin_oe_r, 0);
      axr(8'h20);
      chk_resp(rs, ATX_SLVERR);
      chk(rd, 0);
      axw(ATX_STAT_OFS, 32'hFFFF_FFFF, ATX_SLVERR);
      for (k = 0; k < 3; k++) begin
         axw(ATX_CTRL_OFS, 32'(k * 16), ATX_OKAY);
         axr(ATX_MODE_OFS);
         chk({rd[6], rd[5:4]}, k);
      end
      // Upper lanes only: byte 0 must keep the ratio code
      s_axi_wstrb <= 4'hE;
      axw(ATX_CTRL_OFS, 32'hFFFF_FFFF, ATX_OKAY);
      s_axi_wstrb <= 4'hF;
      axr(ATX_CTRL_OFS);
      chk(rd, 32'hFFFF_FF20);
      $display("test registers done");
      ev(8'h04);
      cyc(3);
      chk(irq_r, 0);
      axw(ATX_MASK_OFS, 32'h0000_0004, ATX_OKAY);
      cyc(3);
      chk({irq_r, int_pin_o_r, int_pin_oe_r}, 3'b101);
      cyc(10);
      chk(irq_r, 1);
      axr(ATX_STAT_OFS);
      chk(rd, 32'h0000_0004);
      cyc(3);
      chk({irq_r, int_pin_o_r}, 2'b01);
      axw(ATX_CTRL_OFS, 32'h0000_0006, ATX_OKAY);
      ev(8'h04);
      cyc(3);
      chk({int_pin_o_r, int_pin_oe_r}, 2'b10);
      axr(ATX_STAT_OFS);
      chk(rd, 32'h0000_0004);
      cyc(3);
      chk({int_pin_o_r, int_pin_oe_r}, 2'b01);
      $display("test interrupt done");
      axw(ATX_CTRL_OFS, 32'h0000_0001, ATX_OKAY);
      axw(ATX_UBUF_OFS, UB, ATX_OKAY);
      cyc(2);
      chk(user_pin_oe_r, 1);
      for (k = 0; k < 3; k++) begin
         chk({user_tx_bit_r, user_pin_o_r}, {2{UB[k]}});
         user_bit_req <= 1'b1;
         @(posedge clk);
         user_bit_req <= 1'b0;
         cyc(2);
      end
      axw(ATX_CTRL_OFS, 32'h0000_0000, ATX_OKAY);
      ext_en <= 1'b1;
      ext_val <= 1'b1;
      cyc(6);
      chk({user_pin_oe_r, user_tx_bit_r}, 2'b01);
      ext_en <= 1'b0;
      cyc(6);
      chk(user_tx_bit_r, 0);
      $display("test user pin done");
      axw(ATX_CTRL_OFS, 32'h0000_0008, ATX_OKAY);
      far.send(8'hA5);
      cyc(6);
      chk({sh, 8'(nin), 8'(nout)}, 24'hA5_0808);
      axw(ATX_CTRL_OFS, 32'h0000_0000, ATX_OKAY);
      far.hold(1'b1);
      cyc(6);
      chk(chip_addr_bit1_r, 1);
      $display("test control port done");
      hw_cfg_pins <= 4'hA;
      tx_line_bit <= 1'b1;
      audio_in <= {24'h12_3456, 24'h65_4321, 1'b1};
      cyc(3);
      chk(audio_out_r | line_driver_pos_r, 0);
      axw(ATX_CTRL_OFS, 32'h0000_0040, ATX_OKAY);
      cyc(3);
      chk({line_driver_pos_r, line_driver_neg_r}, 2'b10);
      rst_to(1'b1);
      chk({cfg_r.hw_mode, cfg_r.alt}, 5'h1A);
      chk(audio_out_r, {24'h12_3456, 24'h65_4321, 1'b1});
      chk({line_driver_pos_r, line_driver_neg_r}, 2'b10);
      tx_line_bit <= 1'b0;
      cyc(3);
      chk({line_driver_pos_r, line_driver_neg_r}, 2'b01);
      axw(ATX_CTRL_OFS, 32'h0000_0001, ATX_OKAY);
      cyc(3);
      chk(user_pin_oe_r, 0);
      $display("test hardware mode done");
      complete_run;
   end
endmodule
